// ==== rtl/ptc_map.vh ====
`ifndef PTC_MAP_VH
`define PTC_MAP_VH
// ********************
// register byte addresses
// ********************
`define PTC_LCTL_ADDR 12'h000
`define PTC_UCTL_ADDR 12'h004
`define PTC_LCNT_ADDR 12'h008
`define PTC_UCNT_ADDR 12'h00C
`define PTC_LPER_ADDR 12'h010
`define PTC_UPER_ADDR 12'h014
`define PTC_STAT_ADDR 12'h018
// ********************
// control fields
// ********************
`define PTC_RUN_BIT 15
`define PTC_IDLE_BIT 13
`define PTC_GATE_BIT 6
`define PTC_PS_HI 5
`define PTC_PS_LO 4
`define PTC_PAIR_BIT 3
`define PTC_CS_BIT 1
`define PTC_LCTL_MASK 16'hA07A
`define PTC_UCTL_MASK 16'hA072
`define PTC_CTL_RESET 16'h0000
// ********************
// prescale terminal counts
// ********************
`define PTC_PS_256 8'hFF
`define PTC_PS_64 8'h3F
`define PTC_PS_8 8'h07
`define PTC_PS_1 8'h00
`endif

// ==== rtl/ptc_top.v ====
`timescale 1ns/10ps
`default_nettype none
`include "ptc_map.vh"
module ptc_top (
  // clock and reset
  input wire sys_clk_i,
  input wire nrst_i,
  // apb slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  // device and pins
  input wire idle_mode_i,
  input wire lower_ext_count_pin_i,
  input wire lower_gate_i,
  input wire upper_ext_count_pin_i,
  input wire upper_gate_i,
  // period match events
  output reg lower_match_o,
  output reg upper_match_o
);

  // ********************
  // registers
  // ********************
  reg [15:0] lctl_q;
  reg [15:0] uctl_q;
  reg [15:0] lcnt_q;
  reg [15:0] ucnt_q;
  reg [15:0] lper_q;
  reg [15:0] uper_q;
  reg [1:0] lflag_q;
  reg [31:0] prdata_q;
  reg [2:0] lpin_q;
  reg [2:0] upin_q;
  reg [1:0] lgate_q;
  reg [1:0] ugate_q;
  reg [1:0] idle_q;
  reg [7:0] lps_q;
  reg [7:0] ups_q;

  // prescale terminal count from the select field
  function [7:0] ps_term;
    input [1:0] sel;
    begin
      case (sel)
        2'b11: ps_term = `PTC_PS_256;
        2'b10: ps_term = `PTC_PS_64;
        2'b01: ps_term = `PTC_PS_8;
        default: ps_term = `PTC_PS_1;
      endcase
    end
  endfunction

  // qualifies one input tick by run, idle, source and gate settings
  function raw_tick;
    input [15:0] ctl;
    input ext_rise;
    input gate;
    input idle;
    begin
      if (!ctl[`PTC_RUN_BIT] || (idle && ctl[`PTC_IDLE_BIT]))
        raw_tick = 1'b0;
      else if (ctl[`PTC_CS_BIT])
        raw_tick = ext_rise;
      else if (ctl[`PTC_GATE_BIT])
        raw_tick = gate;
      else
        raw_tick = 1'b1;
    end
  endfunction

  // ********************
  // input synchronisers
  // ********************
  // third stage only feeds the edge detector, never the first flop
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lpin_q <= 3'h0;
      upin_q <= 3'h0;
      lgate_q <= 2'h0;
      ugate_q <= 2'h0;
      idle_q <= 2'h0;
    end else begin
      lpin_q <= {lpin_q[1:0], lower_ext_count_pin_i};
      upin_q <= {upin_q[1:0], upper_ext_count_pin_i};
      lgate_q <= {lgate_q[0], lower_gate_i};
      ugate_q <= {ugate_q[0], upper_gate_i};
      idle_q <= {idle_q[0], idle_mode_i};
    end
  end

  // ********************
  // tick and match logic
  // ********************
  wire pair_w = lctl_q[`PTC_PAIR_BIT];
  wire lraw_w = raw_tick(lctl_q, lpin_q[1] & ~lpin_q[2], lgate_q[1],
    idle_q[1]);
  // upper control is ignored while paired
  wire uraw_w = raw_tick(uctl_q, upin_q[1] & ~upin_q[2], ugate_q[1],
    idle_q[1]);
  wire [7:0] lterm_w = ps_term(lctl_q[`PTC_PS_HI:`PTC_PS_LO]);
  wire [7:0] uterm_w = ps_term(uctl_q[`PTC_PS_HI:`PTC_PS_LO]);
  // at or past terminal count, so a smaller new ratio never waits a full wrap
  wire ltick_w = lraw_w && (lps_q >= lterm_w);
  wire utick_w = uraw_w && (ups_q >= uterm_w) && !pair_w;
  wire lmatch_w = (lcnt_q == lper_q);
  wire umatch_w = (ucnt_q == uper_q);
  wire wmatch_w = lmatch_w && umatch_w;
  wire wr_w = psel_i && penable_i && pwrite_i;

  // prescalers count qualified input ticks and hold between them, so that
  // sparse external edges and gated time still accumulate through the divide
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lps_q <= 8'h00;
      ups_q <= 8'h00;
    end else begin
      if (!lctl_q[`PTC_RUN_BIT] || ltick_w)
        lps_q <= 8'h00;
      else if (lraw_w)
        lps_q <= lps_q + 8'h01;
      if (!uctl_q[`PTC_RUN_BIT] || pair_w || utick_w)
        ups_q <= 8'h00;
      else if (uraw_w)
        ups_q <= ups_q + 8'h01;
    end
  end

  // counters, control registers and match pulses
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lctl_q <= `PTC_CTL_RESET;
      uctl_q <= `PTC_CTL_RESET;
      lcnt_q <= 16'h0000;
      ucnt_q <= 16'h0000;
      lper_q <= 16'hFFFF;
      uper_q <= 16'hFFFF;
      lflag_q <= 2'h0;
      lower_match_o <= 1'b0;
      upper_match_o <= 1'b0;
    end else begin
      lower_match_o <= 1'b0;
      upper_match_o <= 1'b0;
      if (pair_w) begin
        if (ltick_w) begin
          // lower word low, upper word high
          if (wmatch_w) begin
            lcnt_q <= 16'h0000;
            ucnt_q <= 16'h0000;
            upper_match_o <= 1'b1;
          end else begin
            {ucnt_q, lcnt_q} <= {ucnt_q, lcnt_q} + 32'h0000_0001;
          end
        end
      end else begin
        if (ltick_w) begin
          if (lmatch_w) begin
            lcnt_q <= 16'h0000;
            lower_match_o <= 1'b1;
          end else
            lcnt_q <= lcnt_q + 16'h0001;
        end
        if (utick_w) begin
          if (umatch_w) begin
            ucnt_q <= 16'h0000;
            upper_match_o <= 1'b1;
          end else
            ucnt_q <= ucnt_q + 16'h0001;
        end
      end
      // sticky flags: set wins over a same-cycle clear
      lflag_q <= (lflag_q & ~((wr_w && paddr_i == `PTC_STAT_ADDR) ?
        pwdata_i[1:0] : 2'h0)) |
        {(ltick_w && (pair_w ? wmatch_w : 1'b0)) || (utick_w && umatch_w),
        ltick_w && !pair_w && lmatch_w};
      if (wr_w) begin
        case (paddr_i)
          `PTC_LCTL_ADDR: lctl_q <= pwdata_i[15:0] & `PTC_LCTL_MASK;
          `PTC_UCTL_ADDR: uctl_q <= pwdata_i[15:0] & `PTC_UCTL_MASK;
          `PTC_LCNT_ADDR: lcnt_q <= pwdata_i[15:0];
          `PTC_UCNT_ADDR: ucnt_q <= pwdata_i[15:0];
          `PTC_LPER_ADDR: lper_q <= pwdata_i[15:0];
          `PTC_UPER_ADDR: uper_q <= pwdata_i[15:0];
          default: lper_q <= lper_q;
        endcase
      end
    end
  end

  // ********************
  // apb read path
  // ********************
  // read data is registered during setup so the access phase ends at once
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      case (paddr_i)
        `PTC_LCTL_ADDR: prdata_q <= {16'h0000, lctl_q};
        `PTC_UCTL_ADDR: prdata_q <= {16'h0000, uctl_q};
        `PTC_LCNT_ADDR: prdata_q <= {16'h0000, lcnt_q};
        `PTC_UCNT_ADDR: prdata_q <= {16'h0000, ucnt_q};
        `PTC_LPER_ADDR: prdata_q <= {16'h0000, lper_q};
        `PTC_UPER_ADDR: prdata_q <= {16'h0000, uper_q};
        `PTC_STAT_ADDR: prdata_q <= {30'h0, lflag_q};
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign prdata_o = prdata_q;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && (paddr_i > `PTC_STAT_ADDR ||
    paddr_i[1:0] != 2'b00);

endmodule // ptc_top
`default_nettype wire

// ==== tb/ptc_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
module ptc_sva (
  // clock, reset, bus
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  // pins and events
  input wire logic idle_mode_i,
  input wire logic lower_ext_count_pin_i,
  input wire logic lower_gate_i,
  input wire logic lower_match_o,
  input wire logic upper_match_o
);
  logic [15:0] c_q;
  wire logic acc = psel_i & penable_i;
  // shadow of lower control, since the register is hidden
  always @(posedge sys_clk_i or negedge nrst_i)
    if (!nrst_i) c_q <= 16'h0000;
    else if (acc & pwrite_i & paddr_i == 12'h000) c_q <= pwdata_i[15:0];
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // run off long enough for the sync and pulse stages to drain
  sequence s_off(bit p); (!c_q[15] && c_q[3] == p)[*6]; endsequence
  property p_rdl; acc && !pwrite_i && paddr_i == 12'h000 |->
    (prdata_o & 32'hFFFF5F85) == 0; endproperty
  property p_rdu; acc && !pwrite_i && paddr_i == 12'h004 |->
    (prdata_o & 32'hFFFF5F8D) == 0; endproperty
  property p_stop; s_off(0) |-> !lower_match_o; endproperty
  property p_stop32; s_off(1) |-> !upper_match_o; endproperty
  property p_pair; c_q[3][*3] |-> !lower_match_o; endproperty
  property p_idle; (c_q[13] && idle_mode_i)[*8] |-> !lower_match_o;
  endproperty
  property p_gate; (!c_q[1] && c_q[6] && !lower_gate_i)[*8] |->
    !lower_match_o; endproperty
  property p_ext; (c_q[1] && !lower_ext_count_pin_i)[*8] |->
    !lower_match_o; endproperty
  a_rdl: assert property (p_rdl) else $error("lower ctl reads 1");
  a_rdu: assert property (p_rdu) else $error("upper ctl reads 1");
  a_stop: assert property (p_stop) else $error("stopped lower");
  a_stop32: assert property (p_stop32) else $error("stopped 32");
  a_pair: assert property (p_pair) else $error("lower flag paired");
  a_idle: assert property (p_idle) else $error("counts in idle");
  a_gate: assert property (p_gate) else $error("counts gated");
  a_ext: assert property (p_ext) else $error("counts no edge");
endmodule // ptc_sva
bind ptc_top ptc_sva ptc_sva_inst (.sys_clk_i, .nrst_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .idle_mode_i,
  .lower_ext_count_pin_i, .lower_gate_i, .lower_match_o, .upper_match_o);
`default_nettype wire

// ==== tb/ptc_pin_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module ptc_pin_model (
  // clock and pace
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic [3:0] half_i,
  // count pin
  output logic pin_o
);
  logic [3:0] cnt_q = 4'h0;
  logic pin_q = 1'b0;
  assign pin_o = pin_q;
  // square wave; rests low when idle so no stray edge is seen
  always @(posedge clk_i) begin
    cnt_q <= (!run_i || cnt_q == half_i) ? 4'h0 : cnt_q + 4'h1;
    if (!run_i) pin_q <= 1'b0;
    else if (cnt_q == half_i) pin_q <= ~pin_q;
  end
endmodule // ptc_pin_model
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "ptc_map.vh"
module testbench;
  logic clk = 0, rst_n = 0, sel = 0, en = 0, wr = 0, idle = 0, gate = 0;
  logic mrun = 0, se;
  logic [3:0] half = 0;
  logic [11:0] adr = 0;
  logic [31:0] wd = 0, rd, r, v;
  wire logic rdy, err, lm, um, pin;
  int fails = 0, cmp_count = 0, seed = 32'hE3E1;
  ptc_top ptc_top_inst (.sys_clk_i(clk), .nrst_i(rst_n), .psel_i(sel),
    .penable_i(en), .pwrite_i(wr), .paddr_i(adr), .pwdata_i(wd),
    .prdata_o(rd), .pready_o(rdy), .pslverr_o(err), .idle_mode_i(idle),
    .lower_ext_count_pin_i(pin), .lower_gate_i(gate),
    .upper_ext_count_pin_i(1'b0), .upper_gate_i(1'b0),
    .lower_match_o(lm), .upper_match_o(um));
  ptc_pin_model ptc_pin_model_inst (.clk_i(clk), .run_i(mrun),
    .half_i(half), .pin_o(pin));
  // 50 MHz clock
  initial forever #10 clk = ~clk;
  task chk(input string n, input logic [31:0] e, s);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask
  // one apb transfer; held until pready is seen at an edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    sel <= 1; wr <= w; adr <= a; wd <= d;
    @(posedge clk);
    en <= 1;
    do @(posedge clk); while (rdy !== 1'b1);
    r = rd; se = err;
    sel <= 0; en <= 0;
  endtask
  task rc(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk("ctl", e, r);
  endtask
  function int dv(input int k);
    return k == 3 ? 256 : k == 2 ? 64 : k == 1 ? 8 : 1;
  endfunction
  // spacing between the second and third pulses, so a stale phase from the old setup drops out
  task gap(input logic up, input int e);
    int n;
    repeat (3) begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while ((up ? um : lm) !== 1'b1 && n < 3000);
    end
    chk("interval", e, n);
  endtask
  task none(input logic up);
    int c;
    c = 0;
    repeat (10) @(posedge clk);
    repeat (300) begin
      @(posedge clk);
      c += ((up ? um : lm) !== 1'b0);
    end
    chk("pulses", 0, c);
  endtask
  task wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // watchdog, well past the expected few thousand cycles
  initial begin
    #400000;
    fails++;
    wrap_up;
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1;
    rc(`PTC_LCTL_ADDR, 0);
    rc(`PTC_UCTL_ADDR, 0);
    for (int i = 0; i < 6; i++) begin
      v = i == 0 ? 32'hFFFF : $random(seed);
      apb(1, `PTC_LCTL_ADDR, v);
      rc(`PTC_LCTL_ADDR, v & `PTC_LCTL_MASK);
      apb(1, `PTC_UCTL_ADDR, v);
      rc(`PTC_UCTL_ADDR, v & `PTC_UCTL_MASK);
    end
    apb(0, 12'h01C, 0);
    chk("slverr", 1, se);
    $display("register test done");
    // stop first so no random setup drags the count past the new period
    apb(1, `PTC_LCTL_ADDR, 0);
    apb(1, `PTC_UCTL_ADDR, 0);
    apb(1, `PTC_LPER_ADDR, 3);
    apb(1, `PTC_LCNT_ADDR, 0);
    for (int k = 0; k < 4; k++) begin
      apb(1, `PTC_LCTL_ADDR, 32'h8000 | k << 4);
      gap(0, 4 * dv(k));
    end
    apb(1, `PTC_LCTL_ADDR, 0);
    none(0);
    apb(1, `PTC_LCTL_ADDR, 32'h8040);
    none(0);
    gate <= 1;
    gap(0, 4);
    gate <= 0; half <= 1; mrun <= 1;
    apb(1, `PTC_LCTL_ADDR, 32'h8042);
    gap(0, 16);
    half <= 3;
    gap(0, 32);
    apb(1, `PTC_LCTL_ADDR, 32'h8052);
    gap(0, 256);
    mrun <= 0;
    none(0);
    $display("clock source test done");
    idle <= 1;
    apb(1, `PTC_LCTL_ADDR, 32'hA000);
    none(0);
    apb(1, `PTC_LCTL_ADDR, 32'h8000);
    gap(0, 4);
    idle <= 0;
    apb(1, `PTC_LPER_ADDR, 5);
    apb(1, `PTC_UPER_ADDR, 0);
    apb(1, `PTC_UCNT_ADDR, 0);
    apb(1, `PTC_LCNT_ADDR, 0);
    apb(1, `PTC_UCTL_ADDR, 32'h2030);
    apb(1, `PTC_LCTL_ADDR, 32'h8008);
    gap(1, 6);
    apb(1, `PTC_STAT_ADDR, 3);
    none(0);
    apb(0, `PTC_STAT_ADDR, 0);
    chk("status", 2, r);
    apb(1, `PTC_LCTL_ADDR, 32'h0008);
    none(1);
    $display("pairing test done");
    wrap_up;
  end
endmodule // testbench
`default_nettype wire
